// ### logic/sfph_ctrl.sv
// Top of the serial flash power-state and hold controller.
//
// How it works
// - Standby flag is high while deselected, idle and in standby, not entering, in or leaving deep power-down.
// - In deep power-down every command but resume is ignored, status read too.
// - Opcode B9h then deselect enters deep power-down after the entry delay.
// - Short or unaligned power-down frames are dropped; device stays in standby.
// - Reset always lands in standby, never deep power-down.
// - Power-down is ignored while a program or erase runs; host must reissue.
// - Opcode ABh then deselect returns to standby after the resume delay.
// - Short or unaligned resume frames are dropped; device stays powered down.
// - Hold pauses only the link; busy operations keep running.
// - Hold enters only while selected, at a serial-clock low phase.
// - Hold lasts while hold input and chip select stay asserted.
// - In hold, output tri-states and serial input and clock are ignored.
// - Hold ends at a low phase after the hold input is released.
// - Deselect during hold aborts the frame and clears the write-enable latch.
// - Output launches on falling serial clock, input samples on rising.
`include "sfph_params.svh"
`default_nettype none
module sfph_ctrl (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic sck_link_in,
  input  wire logic cs_n_in,
  input  wire logic si_in,
  input  wire logic hold_n_in,
  input  wire logic wp_n_in,
  input  wire logic busy_in,
  output logic      so_out,
  output logic      so_oe_out,
  output logic      deep_out,
  output logic      standby_out,
  output logic      hold_out,
  output logic      write_enable_latch_out,
  output logic      write_protect_out
);

  // ---------------------------------------------------------------
  // Timing constants.
  // ---------------------------------------------------------------
  localparam logic [`SFPH_DLY_W-1:0] ENTRY_CYC = `SFPH_DLY_W'(`SFPH_ENTRY_CYC);
  localparam logic [`SFPH_DLY_W-1:0] EXIT_CYC  = `SFPH_DLY_W'(`SFPH_EXIT_CYC);

  sfph_pkg::sfph_pwr_type   state_q;
  sfph_pkg::sfph_pwr_type   state_d;
  sfph_pkg::sfph_frame_type frame_w;
  sfph_pkg::sfph_frame_type frame_q;
  logic [`SFPH_DLY_W-1:0]   dly_q;
  logic [`SFPH_DLY_W-1:0]   dly_d;
  logic                     wel_q;
  logic                     wel_d;
  logic                     cs_s;
  logic                     hold_s;
  logic                     wp_s;
  logic                     cs_prev_q;
  logic                     hold_prev_q;

  // ---------------------------------------------------------------
  // Link-side logic on the serial clock.
  // ---------------------------------------------------------------
  // Hold acts in the link logic itself so busy work here never pauses.
  sfph_link u_link (
    .sck_in    (sck_link_in),
    .rst_n_in  (rst_n_in),
    .cs_n_in   (cs_n_in),
    .si_in     (si_in),
    .hold_n_in (hold_n_in),
    .deep_in   (deep_out),
    .stat_in   ({wel_q, busy_in}),
    .frame_out (frame_w),
    .so_out    (so_out),
    .so_oe_out (so_oe_out)
  );

  // ---------------------------------------------------------------
  // Pin synchronisers into the controller clock.
  // ---------------------------------------------------------------
  // Inverted so that an asserted pin reads as one.
  logic [2:0] pins_s;
  sfph_sync #(.W(3)) u_pin_sync (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n_in),
    .d_in     ({cs_n_in, hold_n_in, wp_n_in}),
    .init_in  (3'h7),
    .q_out    (pins_s)
  );
  assign cs_s   = pins_s[2];
  assign hold_s = pins_s[1];
  assign wp_s   = pins_s[0];

  // ---------------------------------------------------------------
  // Frame end detection and opcode decode.
  // ---------------------------------------------------------------
  // The link clock is stopped once chip select is high, so the frame
  // summary is stable by the time the synchronised deselect arrives.
  wire frame_end   = cs_prev_q && !cs_s;
  wire aligned     = frame_w.byte_done && (frame_w.bit_mod == 3'h0);
  wire hold_abort  = frame_end && hold_prev_q;
  wire cmd_ok      = frame_end && aligned && !hold_prev_q;
  wire is_pd       = cmd_ok && (frame_w.opcode == `SFPH_OP_POWERDOWN);
  wire is_resume   = cmd_ok && (frame_w.opcode == `SFPH_OP_RESUME);
  wire is_wren     = cmd_ok && (frame_w.opcode == `SFPH_OP_WRITE_EN);
  wire is_wrdis    = cmd_ok && (frame_w.opcode == `SFPH_OP_WRITE_DIS);
  wire in_standby  = (state_q == sfph_pkg::PWR_STANDBY);
  wire in_deep     = (state_q == sfph_pkg::PWR_DEEP);
  wire pd_accept   = is_pd && in_standby && !busy_in;
  wire standby_d   = in_standby && !cs_s && !busy_in;
  wire hold_d      = cs_s && hold_s;

  // ---------------------------------------------------------------
  // Power-state next value.
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    dly_d   = dly_q;
    case (state_q)
      sfph_pkg::PWR_STANDBY: begin
        if (pd_accept) begin
          state_d = sfph_pkg::PWR_ENTERING;
          dly_d   = ENTRY_CYC - `SFPH_DLY_W'(1);
        end
      end
      sfph_pkg::PWR_ENTERING: begin
        if (dly_q == '0) begin
          state_d = sfph_pkg::PWR_DEEP;
        end else begin
          dly_d = dly_q - `SFPH_DLY_W'(1);
        end
      end
      sfph_pkg::PWR_DEEP: begin
        if (is_resume) begin
          state_d = sfph_pkg::PWR_EXITING;
          dly_d   = EXIT_CYC - `SFPH_DLY_W'(1);
        end
      end
      sfph_pkg::PWR_EXITING: begin
        if (dly_q == '0) begin
          state_d = sfph_pkg::PWR_STANDBY;
        end else begin
          dly_d = dly_q - `SFPH_DLY_W'(1);
        end
      end
      default: begin
        state_d = sfph_pkg::PWR_STANDBY;
        dly_d   = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Write-enable latch next value.
  // ---------------------------------------------------------------
  // Commands reach the latch only in standby; deep power-down ignores them.
  always_comb begin
    wel_d = wel_q;
    if (hold_abort) begin
      wel_d = 1'b0;
    end else if (is_wren && in_standby) begin
      wel_d = 1'b1;
    end else if (is_wrdis && in_standby) begin
      wel_d = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= sfph_pkg::PWR_STANDBY;
      dly_q   <= '0;
      wel_q   <= `SFPH_WEL_RESET;
    end else begin
      state_q <= state_d;
      dly_q   <= dly_d;
      wel_q   <= wel_d;
    end
  end

  // ---------------------------------------------------------------
  // Frame edge history and output flops.
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_prev_q   <= 1'b0;
      hold_prev_q <= 1'b0;
      frame_q     <= '0;
    end else begin
      cs_prev_q   <= cs_s;
      hold_prev_q <= hold_s;
      if (frame_end) begin
        frame_q <= frame_w;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      deep_out               <= 1'b0;
      standby_out            <= 1'b0;
      hold_out               <= 1'b0;
      write_enable_latch_out <= `SFPH_WEL_RESET;
      write_protect_out      <= 1'b0;
    end else begin
      deep_out               <= (state_d == sfph_pkg::PWR_DEEP);
      standby_out            <= standby_d;
      hold_out               <= hold_d;
      write_enable_latch_out <= wel_d;
      write_protect_out      <= wp_s;                   // Stays live in hold.
    end
  end

  // ---------------------------------------------------------------
  // Checks in the controller domain.
  // ---------------------------------------------------------------
  AST_DEEP_ONLY_VIA_ENTRY: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(deep_out) |-> $past(state_q) == sfph_pkg::PWR_ENTERING
  ) else $error("Deep power-down reached without entry.");

  AST_ENTRY_TIMED: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_standby && pd_accept) |=>
      (state_q == sfph_pkg::PWR_ENTERING) [*8] ##117 (state_q == sfph_pkg::PWR_ENTERING)
      ##1 (state_q == sfph_pkg::PWR_DEEP)
  ) else $error("Entry delay count is wrong.");

  AST_BUSY_BLOCKS_PD: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (frame_end && busy_in && in_standby) |=> state_q == sfph_pkg::PWR_STANDBY
  ) else $error("Power-down taken while busy.");

  AST_UNALIGNED_STAYS: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (frame_end && !aligned && in_standby) |=> in_standby
  ) else $error("Unaligned frame left standby.");

  AST_RESUME_ABORT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (frame_end && in_deep && !(aligned && frame_w.opcode == `SFPH_OP_RESUME))
      |=> in_deep
  ) else $error("Deep power-down left without a valid resume.");

  // Cycles spent in the exit state; the resume delay is too long for a plain
  // delay in a property, so it is counted here and the count is checked.
  logic [`SFPH_DLY_W-1:0] exit_cnt_q;
  wire                    in_exiting = (state_q == sfph_pkg::PWR_EXITING);

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      exit_cnt_q <= '0;
    end else if (in_exiting) begin
      exit_cnt_q <= exit_cnt_q + `SFPH_DLY_W'(1);
    end else begin
      exit_cnt_q <= '0;
    end
  end

  AST_RESUME_TAKEN: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_deep && is_resume) |=> in_exiting && (exit_cnt_q == '0)
  ) else $error("Resume did not start the exit delay.");

  AST_RESUME_DELAY: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_exiting && (exit_cnt_q == EXIT_CYC - `SFPH_DLY_W'(1))) |=> in_standby
  ) else $error("Resume delay count is wrong.");

  AST_RESUME_NOT_EARLY: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_exiting && (exit_cnt_q < EXIT_CYC - `SFPH_DLY_W'(1))) |=> in_exiting
  ) else $error("Exit delay ended early.");

  AST_DEEP_IGNORES: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_deep && frame_end && !hold_prev_q) |=> $stable(wel_q)
  ) else $error("Command acted during deep power-down.");

  AST_HOLD_ABORT_WEL: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    hold_abort |=> !wel_q ##0 !write_enable_latch_out
  ) else $error("Latch not cleared on deselect in hold.");

  AST_STANDBY_FLAG: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (in_standby && !cs_s && !busy_in) |=> standby_out
  ) else $error("Standby flag missing.");

  AST_HOLD_NEEDS_SELECT: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    hold_out |-> $past(cs_s)
  ) else $error("Hold shown while deselected.");

endmodule
`default_nettype wire

// ### logic/sfph_link.sv
// Serial link front end, clocked by the serial clock.
`include "sfph_params.svh"
`default_nettype none
module sfph_link (
  input  wire logic                    sck_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    si_in,
  input  wire logic                    hold_n_in,
  input  wire logic                    deep_in,
  input  wire logic [1:0]              stat_in,
  output sfph_pkg::sfph_frame_type     frame_out,
  output logic                         so_out,
  output logic                         so_oe_out
);

  // ---------------------------------------------------------------
  // Domain crossing of slow status levels.
  // ---------------------------------------------------------------
  logic [2:0] lvl_s;
  sfph_sync #(.W(3)) u_sync (
    .clk_in   (sck_in),
    .rst_n_in (rst_n_in),
    .d_in     ({deep_in, stat_in}),
    .init_in  (3'h0),
    .q_out    (lvl_s)
  );

  logic       in_frame_q;
  logic [7:0] shift_q;
  logic [2:0] cnt_q;
  logic       done_q;
  logic       reading_q;
  logic [7:0] tx_q;
  logic [2:0] tx_idx_q;

  wire        hold_now  = ~hold_n_in;
  wire [7:0]  next_byte = {shift_q[6:0], si_in};
  wire        status_go = (cnt_q == 3'h7) && !done_q && in_frame_q &&
                          (next_byte == `SFPH_OP_READ_STATUS) && !lvl_s[2];

  // ---------------------------------------------------------------
  // Frame flag: cleared while chip select is high.
  // ---------------------------------------------------------------
  // A new frame restarts the bit count from zero.
  always_ff @(posedge sck_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      in_frame_q <= 1'b0;
    end else if (cs_n_in) begin
      in_frame_q <= 1'b0;
    end else if (!hold_now) begin
      in_frame_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Input shifter: samples on the rising edge, frozen during hold.
  // ---------------------------------------------------------------
  // The frame summary is left standing after chip select rises, since
  // the clock stops then; the fast side reads it only after that.
  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q   <= 8'h00;
      cnt_q     <= 3'h0;
      done_q    <= 1'b0;
      reading_q <= 1'b0;
      tx_q      <= 8'h00;
    end else if (hold_now) begin
      shift_q   <= shift_q;
    end else if (!in_frame_q) begin
      shift_q   <= {7'h00, si_in};
      cnt_q     <= 3'h1;
      done_q    <= 1'b0;
      reading_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (!done_q) begin
        shift_q <= next_byte;                        // Extra bits ignored.
      end
      if (cnt_q == 3'h7) begin
        done_q <= 1'b1;
      end
      if (status_go) begin
        reading_q <= 1'b1;                           // Status read refused when deep.
        tx_q      <= {6'h00, lvl_s[1:0]};
      end
    end
  end

  // ---------------------------------------------------------------
  // Output launch on the falling edge; tri-state in hold or idle.
  // ---------------------------------------------------------------
  always_ff @(negedge sck_in or posedge cs_n_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
      tx_idx_q  <= 3'h7;
    end else if (cs_n_in) begin
      so_oe_out <= 1'b0;
      tx_idx_q  <= 3'h7;
    end else if (hold_now) begin
      so_oe_out <= 1'b0;
    end else if (reading_q) begin
      so_out    <= tx_q[tx_idx_q];
      so_oe_out <= 1'b1;
      tx_idx_q  <= tx_idx_q - 3'h1;
    end
  end

  assign frame_out.opcode    = shift_q;
  assign frame_out.bit_mod   = cnt_q;
  assign frame_out.byte_done = done_q;

  // ---------------------------------------------------------------
  // Checks in the link domain.
  // ---------------------------------------------------------------
  AST_HOLD_TRISTATE: assert property (
    @(negedge sck_in) disable iff (!rst_n_in || cs_n_in)
    so_oe_out |-> $past(hold_n_in)
  ) else $error("Output driven after a hold sample.");

endmodule
`default_nettype wire

// ### logic/sfph_params.svh
// Constants of the serial flash power and hold controller.
`ifndef SFPH_PARAMS_SVH
`define SFPH_PARAMS_SVH

// Command opcodes.
`define SFPH_OP_POWERDOWN   8'hB9
`define SFPH_OP_RESUME      8'hAB
`define SFPH_OP_READ_STATUS 8'h05
`define SFPH_OP_WRITE_EN    8'h06
`define SFPH_OP_WRITE_DIS   8'h04

// Status byte field positions and reset values.
`define SFPH_STAT_BUSY_BIT  0
`define SFPH_STAT_WEL_BIT   1
`define SFPH_WEL_RESET      1'b0

// Timing: delays in ns, clock rate in MHz, cycle counts rounded down (longest times).
`define SFPH_MCLK_MHZ       125
`define SFPH_ENTRY_NS       1000
`define SFPH_EXIT_NS        3000
`define SFPH_ENTRY_CYC      ((`SFPH_ENTRY_NS * `SFPH_MCLK_MHZ) / 1000)
`define SFPH_EXIT_CYC       ((`SFPH_EXIT_NS * `SFPH_MCLK_MHZ) / 1000)
`define SFPH_DLY_W          10

`endif

// ### logic/sfph_pkg.sv
// Types shared by the serial flash power and hold controller.
`default_nettype none
package sfph_pkg;

  // Power states of the device.
  typedef enum logic [1:0] {
    PWR_STANDBY,
    PWR_ENTERING,
    PWR_DEEP,
    PWR_EXITING
  } sfph_pwr_type;

  // Summary of one chip-select frame, handed from the link domain.
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] bit_mod;
    logic       byte_done;
  } sfph_frame_type;

endpackage
`default_nettype wire

// ### logic/sfph_sync.sv
// Two-flip-flop level synchroniser.
`default_nettype none
module sfph_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] init_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_q;

  // ---------------------------------------------------------------
  // Two stages; only the second stage is read outside.
  // ---------------------------------------------------------------
  // The reset value is a constant so the async reset loads no signal.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in ^ init_in;
      q_out  <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ### testbench/sfph_host.sv
// Host serial master model that drives full-cycle frames into the controller.
`default_nettype none
module sfph_host (
  input  wire logic       so_in,
  input  wire logic       so_oe_in,
  output logic            sck_out,
  output logic            cs_n_out,
  output logic            si_out,
  output logic            hold_n_out,
  output logic [7:0]      rx_out,
  output logic            rx_oe_out,
  output logic            rx_valid_out,
  output logic            hold_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Line levels and frame driver
  // ----------------------------------------------------------------------
  logic so_last;
  logic so_wire;

  // A released output line shows the inverse of its last level, so stale data never passes.
  assign so_wire = so_oe_in ? so_in : ~so_last;

  // Remember the last driven level of the output line.
  always @(so_in or so_oe_in) if (so_oe_in) so_last = so_in;

  // Idle levels; the serial clock stands still outside frames.
  initial begin
    sck_out = 1'h0; cs_n_out = 1'h1; si_out = 1'h0; hold_n_out = 1'h1; so_last = 1'h0;
    rx_out = 8'h00; rx_oe_out = 1'h0; rx_valid_out = 1'h0; hold_oe_out = 1'h1;
  end

  // One frame: MSB first, optional hold at bit hold_at, optional deselect while held.
  task automatic frame(input logic [15:0] bits, input int nbits, input int hold_at,
                       input bit quit);
    logic [7:0] rx;
    logic       oe_seen;
    rx = 8'h00;
    oe_seen = 1'h0;
    cs_n_out = 1'h0;
    si_out = bits[15];
    for (int i = 0; i < nbits; i++) begin
      if (i == hold_at) begin
        hold_n_out = 1'h0;
        for (int k = 0; k < 4; k++) begin
          #6 sck_out = 1'h1;
          si_out = ~si_out;
          #6 sck_out = 1'h0;
        end
        hold_oe_out = so_oe_in;
        if (quit) break;
        #3 hold_n_out = 1'h1;
        si_out = bits[15-i];
      end
      #6 sck_out = 1'h1;
      #1 si_out = (i < 15) ? bits[14-i] : 1'h0;
      #4 if (i >= 8) begin
        rx = {rx[6:0], so_wire};
        oe_seen = oe_seen | so_oe_in;
      end
      #1 sck_out = 1'h0;
    end
    #6 cs_n_out = 1'h1;
    if (quit) #60;
    hold_n_out = 1'h1;
    if (bits[15:8] == 8'h05 && nbits == 16) begin
      rx_out = rx;
      rx_oe_out = oe_seen;
      rx_valid_out = 1'h1;
      #1 rx_valid_out = 1'h0;
    end
    #60;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench of the power-state and hold controller.
`include "sfph_params.svh"
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // Signals, design and host
  // ----------------------------------------------------------------------
  logic        mclk_in, rst_n_in, sck, cs_n, si, hold_n, wp_n, busy;
  logic        so, so_oe, deep, standby, hold, write_enable_latch, wprot;
  logic        rx_valid, rx_oe, hold_oe, hold_seen;
  logic [7:0]  rx, op;
  logic [8:0]  exp_q[$];
  logic [8:0]  exp_v;
  logic [31:0] rng;
  int          miscompares, n_tests;
  int          pd_nb[3] = '{5, 7, 12};
  int          rs_nb[2] = '{7, 12};

  sfph_ctrl i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .sck_link_in(sck), .cs_n_in(cs_n),
    .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .busy_in(busy), .so_out(so),
    .so_oe_out(so_oe), .deep_out(deep), .standby_out(standby), .hold_out(hold),
    .write_enable_latch_out(write_enable_latch), .write_protect_out(wprot));

  sfph_host i_host (.so_in(so), .so_oe_in(so_oe), .sck_out(sck), .cs_n_out(cs_n),
    .si_out(si), .hold_n_out(hold_n), .rx_out(rx), .rx_oe_out(rx_oe),
    .rx_valid_out(rx_valid), .hold_oe_out(hold_oe));

  // Controller clock; the host makes its own unrelated 12 ns link clock.
  initial begin
    mclk_in = 1'h0;
    forever #4 mclk_in = ~mclk_in;
  end

  // Note any cycle in which the design reports hold.
  always @(posedge mclk_in) if (hold === 1'h1) hold_seen <= 1'h1;

  // Status read results are checked against the oldest expectation in order.
  always @(posedge rx_valid) begin
    if (exp_q.size() == 0) exp_v = 9'h1FF;
    else exp_v = exp_q.pop_front();
    `CHK(rx_oe, exp_v[8])
    if (exp_v[8]) `CHK(rx, exp_v[7:0])
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Trailing bits are random, since the design must ignore them.
  task automatic send(input logic [7:0] o, input int nb, input int hold_at = -1,
                      input bit quit = 1'h0);
    rng = xs(rng);
    i_host.frame({o, rng[7:0]}, nb, hold_at, quit);
  endtask

  task automatic read_status(input logic [8:0] e);
    exp_q.push_back(e);
    send(8'h05, 16);
  endtask

  // Bounded wait for deep (sel 0) or standby (sel 1); a timeout ends the run.
  task automatic wait_for(input bit sel, input logic val, input int bound);
    int n;
    n = 0;
    while (((sel ? standby : deep) !== val) && n < bound) begin
      @(posedge mclk_in);
      n++;
    end
    if (n >= bound) begin
      miscompares++;
      $display("[FAIL] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n_in = 1'h0; busy = 1'h0; wp_n = 1'h1; hold_seen = 1'h0;
    rng = 32'h00017DBB; miscompares = 0; n_tests = 0;
    repeat (20) @(posedge mclk_in);
    @(negedge mclk_in) rst_n_in = 1'h1;
    repeat (6) @(negedge mclk_in);
    `CHK(deep, 1'h0)
    `CHK(standby, 1'h1)
    send(8'h06, 8, 4);
    `CHK(write_enable_latch, 1'h1)
    `CHK(hold_seen, 1'h1)
    `CHK(hold_oe, 1'h0)
    read_status({1'h1, 8'h02});
    @(negedge mclk_in) wp_n = 1'h0;
    repeat (4) @(negedge mclk_in);
    `CHK(wprot, 1'h1)
    wp_n = 1'h1;
    send(8'h06, 16, 8, 1'h1);
    `CHK(write_enable_latch, 1'h0)
    send(8'h06, 8);
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      op = rng[15:8];
      if (op inside {8'hB9, 8'hAB, 8'h05, 8'h06, 8'h04}) op = op ^ 8'h10;
      send(op, 16);
      `CHK(deep, 1'h0)
      `CHK(write_enable_latch, 1'h1)
    end
    foreach (pd_nb[k]) begin
      send(8'hB9, pd_nb[k]);
      repeat (`SFPH_ENTRY_CYC + 10) @(posedge mclk_in);
      `CHK(deep, 1'h0)
    end
    @(negedge mclk_in) busy = 1'h1;
    repeat (4) @(negedge mclk_in);
    `CHK(standby, 1'h0)
    send(8'hB9, 16);
    repeat (`SFPH_ENTRY_CYC + 10) @(negedge mclk_in);
    `CHK(deep, 1'h0)
    busy = 1'h0;
    send(8'hB9, 16);
    `CHK(deep, 1'h0)
    wait_for(1'h0, 1'h1, `SFPH_ENTRY_CYC + 8);
    `CHK(deep, 1'h1)
    read_status({1'h0, 8'h00});
    send(8'h04, 8);
    `CHK(write_enable_latch, 1'h1)
    foreach (rs_nb[k]) begin
      send(8'hAB, rs_nb[k]);
      repeat (`SFPH_EXIT_CYC + 10) @(posedge mclk_in);
      `CHK(deep, 1'h1)
    end
    send(8'hAB, 16);
    wait_for(1'h0, 1'h0, 20);
    wait_for(1'h1, 1'h1, `SFPH_EXIT_CYC + 10);
    `CHK(standby, 1'h1)
    send(8'h04, 8);
    `CHK(write_enable_latch, 1'h0)
    read_status({1'h1, 8'h00});
    repeat (20) @(posedge mclk_in);
    report_and_stop();
  end
endmodule
`default_nettype wire
